// [pkg/ipt_pkg.sv]
// Purpose: Shared constants and types for the I2C pass-through control block
// Assumes: Register port on clk_in, local I2C logic on the oscillator clock
// Notes:   The oscillator period below is the nominal link-clock period
package ipt_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_I2C_CTL   = 8'h17;
  localparam logic [7:0] ADDR_SCL_HIGH  = 8'h18;
  localparam logic [7:0] ADDR_SCL_LOW   = 8'h19;

  // Reset values
  localparam logic [7:0] RST_I2C_CTL    = 8'h1E;
  localparam logic [7:0] RST_SCL_HIGH   = 8'h7F;
  localparam logic [7:0] RST_SCL_LOW    = 8'h7F;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // Field positions of the I2C control register
  localparam int CTL_PASS_BIT = 7;
  localparam int CTL_HOLD_MSB = 6;
  localparam int CTL_HOLD_LSB = 4;
  localparam int CTL_FILT_MSB = 3;
  localparam int CTL_FILT_LSB = 0;

  // Timing
  localparam int OSC_PERIOD_NS  = 48;
  localparam int FILTER_UNIT_NS = 5;
  localparam int HOLD_UNIT_NS   = 40;
  localparam int HOLD_UNIT_CYC  =
    (HOLD_UNIT_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
  localparam int HIST_LEN       = 8 * HOLD_UNIT_CYC;
  localparam logic [8:0] SCL_EXTRA_CYC = 9'h005;

  // Configuration passed to the oscillator domain
  typedef struct packed {
    logic       pass0;
    logic       pass1;
    logic [2:0] hold;
    logic [3:0] filt;
    logic [7:0] high;
    logic [7:0] low;
    logic [6:0] own_id;
    logic [6:0] deser_id;
    logic [6:0] rslave_id;
    logic       master;
  } ipt_cfg_t;

  // Address capture states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DONE = 2'b10
  } ipt_addr_st_t;

  // Master clock phase
  typedef enum logic {
    PH_LOW  = 1'b0,
    PH_HIGH = 1'b1
  } ipt_phase_t;

endpackage

// [logic/ipt_glitch_filter.sv]
// Purpose: Rejects pulses on one synchronised I2C line up to a set width
// Assumes: raw_in is already synchronised to clk_in
// Notes:   Width is counted in nanoseconds of oscillator time
`timescale 1ns/1ps
module ipt_glitch_filter import ipt_pkg::*; (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       ce_in,
  input  wire logic       raw_in,
  input  wire logic [3:0] depth_in,
  output logic            filt_out
);

  typedef struct packed {
    logic [7:0] acc_ns;
    logic       filt;
  } ipt_flt_st_t;

  ipt_flt_st_t q_reg;
  ipt_flt_st_t q_next;
  logic [7:0]  limit_ns;
  logic [7:0]  acc_add;

  // Accept a new level only once it outlasts the programmed width
  always_comb begin
    limit_ns = 8'(depth_in * FILTER_UNIT_NS);
    acc_add  = 8'(q_reg.acc_ns + 8'(OSC_PERIOD_NS));
    q_next   = q_reg;
    if (ce_in) begin
      if (raw_in == q_reg.filt) begin
        q_next.acc_ns = 8'h00;
      end else if (acc_add > limit_ns) begin
        q_next.filt   = raw_in;
        q_next.acc_ns = 8'h00;
      end else begin
        q_next.acc_ns = acc_add;
      end
    end
  end

  // State register, idle bus level is high
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q_reg <= '{acc_ns: 8'h00, filt: 1'b1};
    end else begin
      q_reg <= q_next;
    end
  end

  assign filt_out = q_reg.filt;

  // A change passes only after more than the programmed width
  filter_width_a: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    ce_in && q_next.filt != q_reg.filt |->
      acc_add > limit_ns)
    else $error("glitch filter accepted a short pulse");

endmodule

// [logic/ipt_phase_timer.sv]
// Purpose: Times one SCL phase of a programmed count plus five periods
// Assumes: start_in is a one-cycle pulse on clk_in
// Notes:   done_out pulses one period early, so the user's own
//          register stage closes the phase after count+5 cycles
`timescale 1ns/1ps
module ipt_phase_timer import ipt_pkg::*; (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       ce_in,
  input  wire logic       start_in,
  input  wire logic [7:0] count_in,
  output logic            busy_out,
  output logic            done_out
);

  typedef struct packed {
    logic [8:0] cnt;
    logic       done;
  } ipt_tmr_st_t;

  ipt_tmr_st_t q_reg;
  ipt_tmr_st_t q_next;

  // Load count plus the fixed extra periods, then count down
  always_comb begin
    q_next = q_reg;
    if (ce_in) begin
      q_next.done = 1'b0;
      if (start_in) begin
        q_next.cnt = {1'b0, count_in} + SCL_EXTRA_CYC;
      end else if (q_reg.cnt != 9'h000) begin
        q_next.cnt  = q_reg.cnt - 9'h001;
        q_next.done = (q_reg.cnt == 9'h002);
      end
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q_reg <= '{cnt: 9'h000, done: 1'b0};
    end else begin
      q_reg <= q_next;
    end
  end

  assign busy_out = (q_reg.cnt != 9'h000);
  assign done_out = q_reg.done;

  // Phase length is the count plus the extra periods
  timer_load_a: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    ce_in && start_in |=>
      q_reg.cnt == {1'b0, $past(count_in)} + SCL_EXTRA_CYC)
    else $error("phase timer loaded a wrong length");

  // Done is flagged as the second-to-last period ends
  timer_done_a: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    ce_in && !start_in && q_reg.cnt == 9'h002 |=>
      done_out && q_reg.cnt == 9'h001)
    else $error("phase timer did not finish on time");

endmodule

// [logic/ipt_passthru_ctrl.sv]
// Purpose: Pass-through, hold, filter and SCL timing control of the
//          local I2C port, with its registers
// Assumes: Registers on clk_in; local bus logic on the oscillator clock
// Notes:   Configuration crosses by a toggle handshake with a stable copy
`timescale 1ns/1ps
module ipt_passthru_ctrl import ipt_pkg::*; (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       ce_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_write_in,
  input  wire logic       reg_read_in,
  output logic      [7:0] reg_rdata_out,
  input  wire logic       second_port_select_in,
  input  wire logic       master_en_in,
  input  wire logic [6:0] own_id_in,
  input  wire logic [6:0] deser_id_in,
  input  wire logic [6:0] rslave_id_in,
  input  wire logic       link_clk_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            scl_oe_out,
  input  wire logic       stretch_req_in,
  input  wire logic       data_ready_in,
  output logic            scl_filt_out,
  output logic            sda_held_out,
  output logic      [6:0] slave_addr_out,
  output logic            fwd_port0_out,
  output logic            fwd_port1_out
);

  // ---- Register side state
  typedef struct packed {
    logic       pass0;
    logic       pass1;
    logic [2:0] hold;
    logic [3:0] filt;
    logic [7:0] high;
    logic [7:0] low;
    logic [7:0] rdata;
    ipt_cfg_t   shadow;
    logic       req;
    logic       busy;
    logic       ack_s1;
    logic       ack_s2;
    logic       live;
  } ipt_reg_st_t;

  // ---- Oscillator side state
  typedef struct packed {
    logic                ce_s1;
    logic                ce_s2;
    logic                scl_s1;
    logic                scl_s2;
    logic                sda_s1;
    logic                sda_s2;
    logic                req_s1;
    logic                req_s2;
    logic                ack;
    ipt_cfg_t            cfg;
    logic [HIST_LEN-1:0] hist;
    logic                sda_held;
    logic                sda_prev;
    logic                scl_prev;
    ipt_addr_st_t        st;
    logic [2:0]          bits;
    logic [6:0]          shift;
    logic [6:0]          addr;
    logic                fwd0;
    logic                fwd1;
    logic                dec;
    logic                m_on;
    ipt_phase_t          mph;
    logic                sh_hold;
    logic                sh_wait;
    logic                sh_served;
    logic                scl_oe;
    logic                scl_o;
  } ipt_link_st_t;

  ipt_reg_st_t         q_reg;
  ipt_reg_st_t         q_next;
  ipt_link_st_t        lq_reg;
  ipt_link_st_t        lq_next;
  ipt_cfg_t            live_cfg;
  logic [1:0]          raw_w;
  logic [1:0]          filt_w;
  logic [HIST_LEN-1:0] hist_next;
  logic [7:0]          byte_w;
  logic                m_start;
  logic [7:0]          m_count;
  logic                m_done;
  logic                s_start;
  logic                s_done;
  logic                start_cond;
  logic                stop_cond;
  logic                scl_rise;

  // Match test for forwarding an address under one pass-all setting
  function automatic logic fwd_match(input logic pass_all,
                                     input logic [6:0] a,
                                     input ipt_cfg_t c);
    if (pass_all) begin
      fwd_match = (a != c.own_id);
    end else begin
      fwd_match = (a == c.deser_id) || (a == c.rslave_id);
    end
  endfunction

  // Configuration as software currently sees it
  always_comb begin
    live_cfg = '{pass0: q_reg.pass0, pass1: q_reg.pass1,
                 hold: q_reg.hold, filt: q_reg.filt,
                 high: q_reg.high, low: q_reg.low,
                 own_id: own_id_in, deser_id: deser_id_in,
                 rslave_id: rslave_id_in, master: master_en_in};
  end

  // Register access and handshake launch
  always_comb begin
    q_next = q_reg;
    q_next.ack_s1 = lq_reg.ack;
    q_next.ack_s2 = q_reg.ack_s1;
    if (ce_in) begin
      q_next.live = 1'b1;
      if (reg_write_in) begin
        case (reg_addr_in)
          ADDR_I2C_CTL: begin
            if (second_port_select_in) begin
              q_next.pass1 = reg_wdata_in[CTL_PASS_BIT];
            end else begin
              q_next.pass0 = reg_wdata_in[CTL_PASS_BIT];
            end
            q_next.hold = reg_wdata_in[CTL_HOLD_MSB:CTL_HOLD_LSB];
            q_next.filt = reg_wdata_in[CTL_FILT_MSB:CTL_FILT_LSB];
          end
          ADDR_SCL_HIGH: q_next.high = reg_wdata_in;
          ADDR_SCL_LOW:  q_next.low  = reg_wdata_in;
          default: ;
        endcase
      end
      if (reg_read_in) begin
        case (reg_addr_in)
          ADDR_I2C_CTL: q_next.rdata = {second_port_select_in ?
                                        q_reg.pass1 : q_reg.pass0,
                                        q_reg.hold, q_reg.filt};
          ADDR_SCL_HIGH: q_next.rdata = q_reg.high;
          ADDR_SCL_LOW:  q_next.rdata = q_reg.low;
          default:       q_next.rdata = RDATA_UNMAPPED;
        endcase
      end
      if (q_reg.busy) begin
        q_next.busy = (q_reg.ack_s2 != q_reg.req);
      end else if (live_cfg != q_reg.shadow) begin
        q_next.shadow = live_cfg;
        q_next.req    = ~q_reg.req;
        q_next.busy   = 1'b1;
      end
    end
  end

  // Register side flops
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q_reg <= '{pass0: RST_I2C_CTL[CTL_PASS_BIT],
                 pass1: RST_I2C_CTL[CTL_PASS_BIT],
                 hold: RST_I2C_CTL[CTL_HOLD_MSB:CTL_HOLD_LSB],
                 filt: RST_I2C_CTL[CTL_FILT_MSB:CTL_FILT_LSB],
                 high: RST_SCL_HIGH, low: RST_SCL_LOW,
                 rdata: RDATA_UNMAPPED, shadow: '0,
                 default: 1'b0};
    end else begin
      q_reg <= q_next;
    end
  end

  assign reg_rdata_out = q_reg.rdata;

  // Glitch filters for SCL (bit 0) and SDA (bit 1)
  assign raw_w = {lq_reg.sda_s2, lq_reg.scl_s2};
  for (genvar gi = 0; gi < 2; gi++) begin : g_flt
    ipt_glitch_filter u_flt (
      .clk_in     (link_clk_in),
      .reset_n_in (reset_n_in),
      .ce_in      (lq_reg.ce_s2),
      .raw_in     (raw_w[gi]),
      .depth_in   (lq_reg.cfg.filt),
      .filt_out   (filt_w[gi])
    );
  end

  // Timer for the master clock phases
  ipt_phase_timer u_mtmr (
    .clk_in     (link_clk_in),
    .reset_n_in (reset_n_in),
    .ce_in      (lq_reg.ce_s2),
    .start_in   (m_start),
    .count_in   (m_count),
    .busy_out   (),
    .done_out   (m_done)
  );

  // Timer for the slave data setup interval
  ipt_phase_timer u_stmr (
    .clk_in     (link_clk_in),
    .reset_n_in (reset_n_in),
    .ce_in      (lq_reg.ce_s2),
    .start_in   (s_start),
    .count_in   (lq_reg.cfg.low),
    .busy_out   (),
    .done_out   (s_done)
  );

  // Bus events on the filtered SCL and the filtered, hold-delayed SDA
  always_comb begin
    hist_next  = {lq_reg.hist[HIST_LEN-2:0], filt_w[1]};
    byte_w     = {lq_reg.shift, lq_reg.sda_held};
    start_cond = filt_w[0] && lq_reg.sda_prev && !lq_reg.sda_held;
    stop_cond  = filt_w[0] && !lq_reg.sda_prev && lq_reg.sda_held;
    scl_rise   = filt_w[0] && !lq_reg.scl_prev;
  end

  // Oscillator side behaviour
  always_comb begin
    lq_next = lq_reg;
    m_start = 1'b0;
    m_count = lq_reg.cfg.low;
    s_start = 1'b0;
    lq_next.ce_s1  = ce_in;
    lq_next.ce_s2  = lq_reg.ce_s1;
    lq_next.scl_s1 = scl_in;
    lq_next.scl_s2 = lq_reg.scl_s1;
    lq_next.sda_s1 = sda_in;
    lq_next.sda_s2 = lq_reg.sda_s1;
    lq_next.req_s1 = q_reg.req;
    lq_next.req_s2 = lq_reg.req_s1;
    if (lq_reg.ce_s2) begin
      lq_next.dec = 1'b0;
      // Take the stable configuration copy
      if (lq_reg.req_s2 != lq_reg.ack) begin
        lq_next.cfg = q_reg.shadow;
        lq_next.ack = lq_reg.req_s2;
      end
      // Internal SDA hold behind SCL
      lq_next.hist     = hist_next;
      lq_next.sda_held =
        hist_next[int'(lq_reg.cfg.hold) * HOLD_UNIT_CYC];
      lq_next.sda_prev = lq_reg.sda_held;
      lq_next.scl_prev = filt_w[0];
      // Capture the slave address and decide forwarding
      if (start_cond) begin
        lq_next.st   = ST_ADDR;
        lq_next.bits = 3'h0;
        lq_next.fwd0 = 1'b0;
        lq_next.fwd1 = 1'b0;
      end else if (stop_cond) begin
        lq_next.st   = ST_IDLE;
        lq_next.fwd0 = 1'b0;
        lq_next.fwd1 = 1'b0;
      end else begin
        case (lq_reg.st)
          ST_IDLE: ;
          ST_ADDR: begin
            if (scl_rise) begin
              lq_next.shift = byte_w[6:0];
              lq_next.bits  = lq_reg.bits + 3'h1;
              if (lq_reg.bits == 3'h7) begin
                lq_next.addr = byte_w[7:1];
                lq_next.fwd0 = fwd_match(lq_reg.cfg.pass0,
                                         byte_w[7:1], lq_reg.cfg);
                lq_next.fwd1 = fwd_match(lq_reg.cfg.pass1,
                                         byte_w[7:1], lq_reg.cfg);
                lq_next.dec  = 1'b1;
                lq_next.st   = ST_DONE;
              end
            end
          end
          ST_DONE: ;
          default: lq_next.st = ST_IDLE;
        endcase
      end
      // Master SCL generation, low phase first
      if (!lq_reg.m_on) begin
        if (lq_reg.cfg.master) begin
          lq_next.m_on = 1'b1;
          lq_next.mph  = PH_LOW;
          m_start      = 1'b1;
        end
      end else if (m_done) begin
        if (!lq_reg.cfg.master) begin
          lq_next.m_on = 1'b0;
        end else if (lq_reg.mph == PH_LOW) begin
          lq_next.mph = PH_HIGH;
          m_count     = lq_reg.cfg.high;
          m_start     = 1'b1;
        end else begin
          lq_next.mph = PH_LOW;
          m_start     = 1'b1;
        end
      end
      // Slave stretch: release SCL a setup interval after data
      if (!stretch_req_in) begin
        lq_next.sh_served = 1'b0;
        lq_next.sh_hold   = 1'b0;
        lq_next.sh_wait   = 1'b0;
      end else if (!lq_reg.sh_served && !lq_reg.sh_hold) begin
        lq_next.sh_hold = 1'b1;
      end else if (lq_reg.sh_hold && !lq_reg.sh_wait && data_ready_in) begin
        lq_next.sh_wait = 1'b1;
        s_start         = 1'b1;
      end else if (lq_reg.sh_wait && s_done) begin
        lq_next.sh_hold   = 1'b0;
        lq_next.sh_wait   = 1'b0;
        lq_next.sh_served = 1'b1;
      end
      lq_next.scl_oe = (lq_next.m_on && lq_next.mph == PH_LOW) ||
                       lq_next.sh_hold;
    end
  end

  // Oscillator side flops
  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lq_reg <= '{cfg: '0, hist: '1, st: ST_IDLE, mph: PH_LOW,
                  bits: 3'h0, shift: 7'h00, addr: 7'h00,
                  sda_held: 1'b1, sda_prev: 1'b1, scl_prev: 1'b1,
                  scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1,
                  sda_s2: 1'b1, default: 1'b0};
    end else begin
      lq_reg <= lq_next;
    end
  end

  // Outputs straight from flops
  assign scl_out        = lq_reg.scl_o;
  assign scl_oe_out     = lq_reg.scl_oe;
  assign scl_filt_out   = filt_w[0];
  assign sda_held_out   = lq_reg.sda_held;
  assign slave_addr_out = lq_reg.addr;
  assign fwd_port0_out  = lq_reg.fwd0;
  assign fwd_port1_out  = lq_reg.fwd1;

  // Control register reset value
  ctl_reset_a: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    !q_reg.live |-> {q_reg.pass0, q_reg.hold, q_reg.filt} == RST_I2C_CTL)
    else $error("control register reset value wrong");

  // Clock timing reset values
  time_reset_a: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    !q_reg.live |-> q_reg.high == RST_SCL_HIGH &&
      q_reg.low == RST_SCL_LOW)
    else $error("clock timing reset value wrong");

  // Port select steers the pass-all write
  port_select_a: assert property (@(posedge clk_in)
    disable iff (!reset_n_in)
    ce_in && reg_write_in && reg_addr_in == ADDR_I2C_CTL &&
    second_port_select_in |=>
      q_reg.pass1 == $past(reg_wdata_in[CTL_PASS_BIT]) &&
      $stable(q_reg.pass0))
    else $error("pass-all write went to the wrong port");

  // Matching mode forwards only remote IDs
  fwd_match_a: assert property (@(posedge link_clk_in)
    disable iff (!reset_n_in)
    lq_reg.dec && !lq_reg.cfg.pass0 |-> fwd_port0_out ==
      (slave_addr_out == lq_reg.cfg.deser_id ||
       slave_addr_out == lq_reg.cfg.rslave_id))
    else $error("matching forward decision wrong");

  // Pass-all mode on port 1 forwards all but own ID
  fwd_all_a: assert property (@(posedge link_clk_in)
    disable iff (!reset_n_in)
    lq_reg.dec && lq_reg.cfg.pass1 |->
      fwd_port1_out == (slave_addr_out != lq_reg.cfg.own_id))
    else $error("pass-all forward decision wrong");

  // Hold code two delays SDA by three oscillator cycles
  sda_hold_a: assert property (@(posedge link_clk_in)
    disable iff (!reset_n_in)
    lq_reg.ce_s2 && $past(lq_reg.ce_s2, 3) && lq_reg.cfg.hold == 3'h2 &&
    $past(lq_reg.cfg.hold, 3) == 3'h2 |=>
      sda_held_out == $past(filt_w[1], 3))
    else $error("SDA hold delay wrong");

  // Stretched SCL released only after the setup interval
  setup_release_a: assert property (@(posedge link_clk_in)
    disable iff (!reset_n_in)
    $fell(lq_reg.sh_hold) && $past(stretch_req_in) |->
      $past(s_done))
    else $error("SCL released before setup interval");

endmodule

// [verif/ipt_i2c_host.sv]
// Purpose: Local I2C host model on the open-drain SCL and SDA lines
// Assumes: Both lines pulled up; an enable high pulls its line low
// Notes:   Bit period is 3H link cycles (SCL low 2H, high H); lines change after edges
`timescale 1ns/1ps
module ipt_i2c_host #(parameter int H = 16) (
  input  wire logic link_clk_in,
  output logic      scl_oe_out,
  output logic      sda_oe_out
);
  // Lines released at start
  initial begin
    scl_oe_out = 1'b0;
    sda_oe_out = 1'b0;
  end
  // Waits n link edges
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk_in);
  endtask
  // START, then address byte MSB first; SCL left high after bit 8
  task automatic send_addr(input logic [7:0] b);
    sda_oe_out <= 1'b1;
    tick(H);
    for (int i = 7; i >= 0; i--) begin
      scl_oe_out <= 1'b1;
      tick(H);
      sda_oe_out <= ~b[i];
      tick(H);
      scl_oe_out <= 1'b0;
      tick(H);
    end
  endtask
  // STOP: SDA rises while SCL is high
  task automatic send_stop();
    scl_oe_out <= 1'b1;
    tick(H);
    sda_oe_out <= 1'b1;
    tick(H);
    scl_oe_out <= 1'b0;
    tick(H);
    sda_oe_out <= 1'b0;
    tick(H);
  endtask
  // Pulls SCL low for n link cycles only
  task automatic pulse_scl(input int n);
    scl_oe_out <= 1'b1;
    tick(n);
    scl_oe_out <= 1'b0;
    tick(H);
  endtask
endmodule

// [verif/i2c_passthrough_timing_ctrl_test.sv]
// Purpose: Self-checking bench of the pass-through control block
// Assumes: Register side on clk, oscillator on link_clk
// Notes:   Link checks wait for the configuration to cross
`timescale 1ns/1ps
module i2c_passthrough_timing_ctrl_test import ipt_pkg::*;;
  typedef struct packed {
    logic       wr;
    logic       sps;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } ipt_row_t;
  localparam int H = 16;
  logic       clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       sps = 1'b0;
  logic       men = 1'b0;
  logic       stretch = 1'b0;
  logic       dready = 1'b0;
  logic [7:0] rdata;
  logic [6:0] saddr;
  logic       scl_o, scl_oe, scl_f, sda_h, fwd0, fwd1, h_scl, h_sda, seen;
  int         fails = 0;
  int         n_compared = 0;
  logic [6:0] ids [4] = '{7'h2C, 7'h33, 7'h0C, 7'h50};
  logic [1:0] fexp [4] = '{2'b11, 2'b01, 2'b00, 2'b11};
  // Write (optional) then read back; unmapped offset 0x1A among them
  ipt_row_t rows [9] = '{
    '{1'b0, 1'b0, ADDR_I2C_CTL, 8'h00, 8'h1E},
    '{1'b0, 1'b0, ADDR_SCL_HIGH, 8'h00, 8'h7F},
    '{1'b0, 1'b0, ADDR_SCL_LOW, 8'h00, 8'h7F},
    '{1'b0, 1'b0, 8'h1A, 8'h00, 8'h00},
    '{1'b1, 1'b0, 8'h1A, 8'h55, 8'h00},
    '{1'b1, 1'b0, ADDR_SCL_HIGH, 8'h03, 8'h03},
    '{1'b1, 1'b0, ADDR_SCL_LOW, 8'h02, 8'h02},
    '{1'b1, 1'b1, ADDR_I2C_CTL, 8'hAE, 8'hAE},
    '{1'b0, 1'b0, ADDR_I2C_CTL, 8'h00, 8'h2E}};

  // Clocks of the two domains
  always #25 clk = ~clk;
  always #24 link_clk = ~link_clk;

  // Open-drain wires with pull-ups
  wire scl_line = ~h_scl & ~(scl_oe & ~scl_o);
  wire sda_line = ~h_sda;

  ipt_passthru_ctrl uut (
    .clk_in(clk), .reset_n_in(reset_n), .ce_in(ce),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr),
    .reg_read_in(rd), .reg_rdata_out(rdata),
    .second_port_select_in(sps), .master_en_in(men),
    .own_id_in(7'h0C), .deser_id_in(7'h2C), .rslave_id_in(7'h50),
    .link_clk_in(link_clk), .scl_in(scl_line), .sda_in(sda_line),
    .scl_out(scl_o), .scl_oe_out(scl_oe), .stretch_req_in(stretch),
    .data_ready_in(dready), .scl_filt_out(scl_f), .sda_held_out(sda_h),
    .slave_addr_out(saddr), .fwd_port0_out(fwd0), .fwd_port1_out(fwd1));

  ipt_i2c_host #(.H(H)) host (.link_clk_in(link_clk),
    .scl_oe_out(h_scl), .sda_oe_out(h_sda));

  // Compares and counts
  task automatic check(input string s, input logic [7:0] e,
                       input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask

  // Register access: optional write, then a read
  task automatic reg_rw(input ipt_row_t r, output logic [7:0] q);
    if (r.wr) begin
      @(posedge clk);
      {sps, addr, wdata, wr} <= {r.sps, r.addr, r.wdata, 1'b1};
      @(posedge clk);
      wr <= 1'b0;
    end
    @(posedge clk);
    {sps, addr, rd} <= {r.sps, r.addr, 1'b1};
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    #1 q = rdata;
  endtask

  // One link edge, then let outputs settle
  task automatic lstep();
    @(posedge link_clk);
    #1;
  endtask

  // Link cycles that SCL enable stays at v, from its next start
  task automatic scl_width(input logic v, output int n);
    n = 0;
    while (scl_oe !== ~v && n < 400) begin lstep(); n++; end
    while (scl_oe !== v && n < 800) begin lstep(); n++; end
    n = 0;
    do begin lstep(); n++; end while (scl_oe === v && n < 400);
  endtask

  // Verdict
  task automatic end_of_test();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    #1000000;
    fails++;
    end_of_test();
  end

  // Main sequence
  initial begin
    logic [7:0] q;
    int n;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      reg_rw(rows[i], q);
      check("reg", rows[i].exp, q);
    end
    repeat (40) @(posedge link_clk);
    // Forward decisions: deser, other, own, remote slave
    for (int i = 0; i < 4; i++) begin
      host.send_addr({ids[i], 1'b0});
      #1 check("fwd", {6'h00, fexp[i]}, {6'h00, fwd0, fwd1});
      check("addr", {1'b0, ids[i]}, {1'b0, saddr});
      host.send_stop();
    end
    // Short SCL pulse rejected, long one passes
    for (int w = 1; w < 5; w += 3) begin
      seen = 1'b0;
      fork
        host.pulse_scl(w);
        repeat (H) begin lstep(); if (scl_f === 1'b0) seen = 1'b1; end
      join
      check("glitch", {7'h00, w > 1}, {7'h00, seen});
    end
    // Master phases of count plus five
    @(posedge clk);
    men <= 1'b1;
    scl_width(1'b1, n);
    check("low", 8'h02 + 8'h05, n[7:0]);
    scl_width(1'b0, n);
    check("high", 8'h03 + 8'h05, n[7:0]);
    @(posedge clk);
    men <= 1'b0;
    repeat (40) @(posedge link_clk);
    // Slave stretch released after the setup interval
    stretch <= 1'b1;
    repeat (3) @(posedge link_clk);
    #1 check("stretch", 8'h01, {7'h00, scl_oe});
    @(posedge link_clk);
    dready <= 1'b1;
    @(posedge link_clk);
    dready <= 1'b0;
    n = 0;
    do begin lstep(); n++; end while (scl_oe === 1'b1 && n < 400);
    check("setup", 8'h02 + 8'h05, n[7:0]);
    @(posedge link_clk);
    stretch <= 1'b0;
    // Clock enable low freezes the registers
    @(posedge clk);
    ce <= 1'b0;
    reg_rw(ipt_row_t'{1'b1, 1'b0, ADDR_SCL_HIGH, 8'h44, 8'h00}, q);
    @(posedge clk);
    ce <= 1'b1;
    reg_rw(rows[1], q);
    check("freeze", rows[5].exp, q);
    // Second reset in mid-run restores defaults
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    #1 check("idle", 8'h04, {3'h0, scl_oe, scl_o, sda_h, fwd0, fwd1});
    reg_rw(rows[1], q);
    check("reset", 8'h7F, q);
    reg_rw(rows[0], q);
    check("reset ctl", 8'h1E, q);
    end_of_test();
  end
endmodule
